// ==== core/motor_driver_mode_control.sv ====
// sleep, disable and active mode control with fault latch and apb registers
`timescale 1ns/1ps
module motor_driver_mode_control
  import mode_ctrl_pkg::*;
#(
  parameter int unsigned CLEAR_MIN_CYCLES = CLEAR_MIN_CYC,
  parameter int unsigned CLEAR_MAX_CYCLES = CLEAR_MAX_CYC,
  parameter int unsigned SLEEP_CYCLES = SLEEP_ENTRY_CYC,
  parameter int unsigned WAKE_CYCLES = WAKE_CYC,
  parameter int unsigned RETRY_CYCLES = RETRY_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic sleep_request_low,
  input wire logic enable_level,
  input wire logic enable_float,
  input wire logic supply_undervoltage_lockout,
  input wire logic overcurrent_trip,
  input wire logic pump_undervoltage,
  input wire logic over_temperature,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic bridge_on,
  output logic pump_run,
  output logic logic_regulator_output,
  output logic ready,
  output logic fault_flag_low_o,
  output logic fault_flag_low_oe,
  output logic irq
);

  // ==========================================================
  // helpers
  function automatic logic reached(input logic [CNT_W-1:0] cnt, input int unsigned lim);
    reached = cnt >= lim[CNT_W-1:0];
  endfunction

  // ==========================================================
  // pin synchronisers
  logic [PIN_W-1:0] pins;
  wire logic [PIN_W-1:0] pin_raw = {over_temperature, pump_undervoltage, overcurrent_trip,
    supply_undervoltage_lockout, enable_float, enable_level, sleep_request_low};

  pin_sync #(.W(PIN_W)) u_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .pin(pin_raw),
    .level(pins)
  );

  wire logic sleep_hi = pins[PIN_SLEEP];
  wire logic en_float = pins[PIN_EN_FLOAT];
  wire logic en_low = !en_float && !pins[PIN_EN_LEVEL];
  wire logic retry_mode = !en_float && pins[PIN_EN_LEVEL];
  wire logic uv_hi = pins[PIN_UV];
  wire logic oc_hi = pins[PIN_OC];
  wire logic cpuv_hi = pins[PIN_CPUV];
  wire logic ot_hi = pins[PIN_OT];

  // ==========================================================
  // state
  mode_t state;
  mode_t next_state;
  logic ocp_latch;
  logic any_fault_q;
  logic soft_off;
  logic [EV_W-1:0] int_status;
  logic [EV_W-1:0] int_mask;
  logic [CNT_W-1:0] low_cnt;
  logic [CNT_W-1:0] wake_cnt;
  logic [CNT_W-1:0] retry_cnt;

  // ==========================================================
  // timers
  span_counter u_low (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .clr(sleep_hi),
    .run(1'b1),
    .count(low_cnt)
  );

  span_counter u_wake (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .clr(state != ST_WAKE),
    .run(1'b1),
    .count(wake_cnt)
  );

  span_counter u_retry (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .clr(!ocp_latch || !retry_mode),
    .run(1'b1),
    .count(retry_cnt)
  );

  wire logic sleep_due = !sleep_hi && reached(low_cnt, SLEEP_CYCLES);
  wire logic wake_done = reached(wake_cnt, WAKE_CYCLES);
  wire logic retry_done = reached(retry_cnt, RETRY_CYCLES);
  wire logic low_end = sleep_hi && (low_cnt != '0);
  wire logic clear_pulse = low_end && reached(low_cnt, CLEAR_MIN_CYCLES + 1);
  wire logic long_pulse = clear_pulse && reached(low_cnt, CLEAR_MAX_CYCLES);
  wire logic run_ok = !en_low && !uv_hi;

  // ==========================================================
  // mode sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      ST_SLEEP: begin
        if (sleep_hi) begin
          next_state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (sleep_due) begin
          next_state = ST_SLEEP;
        end else if (wake_done && sleep_hi) begin
          next_state = run_ok ? ST_ACTIVE : ST_DISABLED;
        end
      end
      ST_DISABLED: begin
        if (sleep_due) begin
          next_state = ST_SLEEP;
        end else if (run_ok) begin
          next_state = ST_WAKE;
        end
      end
      ST_ACTIVE: begin
        if (sleep_due) begin
          next_state = ST_SLEEP;
        end else if (!run_ok) begin
          next_state = ST_DISABLED;
        end
      end
    endcase
  end

  // ==========================================================
  // fault latch and outputs
  wire logic next_ocp = oc_hi ? 1'b1 :
    (state == ST_SLEEP) ? 1'b0 :
    clear_pulse ? 1'b0 :
    (retry_mode && retry_done) ? 1'b0 : ocp_latch;
  wire logic any_fault = next_ocp || uv_hi || cpuv_hi || ot_hi;
  wire logic next_bridge = (next_state == ST_ACTIVE) && !any_fault && !soft_off && !en_low;
  wire logic next_pump = (next_state != ST_SLEEP) && !uv_hi && !ot_hi;

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_WAKE;
      ocp_latch <= 1'b0;
      any_fault_q <= 1'b0;
      bridge_on <= 1'b0;
      pump_run <= 1'b0;
      logic_regulator_output <= 1'b0;
      ready <= 1'b0;
      fault_flag_low_o <= 1'b0;
      fault_flag_low_oe <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      ocp_latch <= next_ocp;
      any_fault_q <= any_fault;
      bridge_on <= next_bridge;
      pump_run <= next_pump;
      logic_regulator_output <= next_state != ST_SLEEP;
      ready <= next_state == ST_ACTIVE;
      fault_flag_low_o <= 1'b0;
      fault_flag_low_oe <= any_fault;
    end
  end

  // ==========================================================
  // apb registers and interrupt
  wire logic setup = psel && !penable;
  wire logic wr_go = psel && penable && pready && pwrite;
  wire logic hit_ctrl = paddr == ADDR_CTRL;
  wire logic hit_stat = paddr == ADDR_STATUS;
  wire logic hit_int = paddr == ADDR_INT_STATUS;
  wire logic hit_mask = paddr == ADDR_INT_MASK;
  wire logic mapped = hit_ctrl || hit_stat || hit_int || hit_mask;
  wire logic [EV_W-1:0] w1c = (wr_go && hit_int) ? pwdata[EV_W-1:0] : '0;
  logic [EV_W-1:0] events;
  logic [31:0] status_word;

  always_comb begin
    events = '0;
    events[EV_FAULT] = any_fault && !any_fault_q;
    events[EV_CLEAR] = clear_pulse;
    events[EV_SLEEP] = (next_state == ST_SLEEP) && (state != ST_SLEEP);
    events[EV_READY] = (next_state == ST_ACTIVE) && (state != ST_ACTIVE);
    events[EV_LONG] = long_pulse;
    status_word = '0;
    status_word[STAT_MODE_LSB +: 2] = state;
    status_word[STAT_BRIDGE] = bridge_on;
    status_word[STAT_PUMP] = pump_run;
    status_word[STAT_READY] = ready;
    status_word[STAT_OCP] = ocp_latch;
    status_word[STAT_UV] = uv_hi;
    status_word[STAT_CPUV] = cpuv_hi;
    status_word[STAT_OT] = ot_hi;
    status_word[STAT_RETRY] = retry_mode;
  end

  wire logic [EV_W-1:0] next_int = (int_status & ~w1c) | events;
  wire logic [EV_W-1:0] next_mask = (wr_go && hit_mask) ? pwdata[EV_W-1:0] : int_mask;
  wire logic [31:0] rd_data = hit_ctrl ? {31'h0, soft_off} :
    hit_stat ? status_word :
    hit_int ? {27'h0, int_status} :
    hit_mask ? {27'h0, int_mask} : 32'h0;

  always_ff @(posedge clk) begin
    if (rst) begin
      soft_off <= CTRL_RESET;
      int_status <= INT_RESET;
      int_mask <= INT_RESET;
      irq <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (ce) begin
      if (wr_go && hit_ctrl) begin
        soft_off <= pwdata[CTRL_SOFT_OFF];
      end
      int_status <= next_int;
      int_mask <= next_mask;
      irq <= |(next_int & next_mask);
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= setup ? rd_data : 32'h0;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_clear_seen;
    ce && !oc_hi && clear_pulse;
  endsequence

  sequence s_short_low;
    ce && low_end && !clear_pulse && ocp_latch && !retry_mode && !oc_hi;
  endsequence

  AST_SLEEP_OFF: assert property (state == ST_SLEEP |-> !bridge_on && !pump_run)
    else $error("power on while asleep");
  AST_SLEEP_DELAY: assert property (
    ce && state != ST_SLEEP ##1 state == ST_SLEEP |-> $past(low_cnt) >= SLEEP_CYCLES)
    else $error("sleep entered before the entry delay");
  AST_WAKE_SELF: assert property (ce && state == ST_SLEEP && sleep_hi |=> state == ST_WAKE)
    else $error("no wake on high sleep input");
  AST_READY_DELAY: assert property ($rose(ready) |-> $past(wake_cnt) >= WAKE_CYCLES)
    else $error("ready before the wake delay");
  AST_EN_LOW: assert property (ce && en_low |=> !bridge_on)
    else $error("bridge on while enable low");
  AST_ACTIVE_COND: assert property ($rose(ready) |-> $past(sleep_hi && !en_low && !uv_hi))
    else $error("active entered without its conditions");
  AST_CLEAR: assert property (s_clear_seen |=> !ocp_latch)
    else $error("fault not cleared by the pulse");
  AST_SHORT_KEEPS: assert property (s_short_low |=> ocp_latch)
    else $error("short pulse cleared the fault");
  AST_PULSE_NO_SLEEP: assert property (
    s_clear_seen and state != ST_SLEEP |=> state != ST_SLEEP)
    else $error("clearing pulse changed sleep state");
  AST_RETRY: assert property (
    $fell(ocp_latch) |-> $past(retry_done || clear_pulse || state == ST_SLEEP))
    else $error("overcurrent released without cause");
  AST_FAULT_PIN: assert property (ce && any_fault |=> fault_flag_low_oe)
    else $error("fault output not driven");
  AST_IRQ: assert property (irq == |(int_status & int_mask))
    else $error("interrupt does not follow status and mask");

endmodule

// ==== common/mode_ctrl_pkg.sv ====
// constants, register map and state encoding for the motor driver mode control
package mode_ctrl_pkg;

  // ==========================================================
  // clock and timing
  localparam int CLK_MHZ = 250;
  localparam int CNT_W = 20;
  localparam int CLEAR_MIN_US = 18;
  localparam int CLEAR_MAX_US = 35;
  localparam int SLEEP_ENTRY_US = 75;
  localparam int WAKE_US = 1000;
  localparam int RETRY_US = 4000;
  // least times round up, longest round down; whole microseconds are exact here
  localparam int CLEAR_MIN_CYC = CLEAR_MIN_US * CLK_MHZ;
  localparam int CLEAR_MAX_CYC = CLEAR_MAX_US * CLK_MHZ;
  localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_US * CLK_MHZ;
  localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
  localparam int RETRY_CYC = RETRY_US * CLK_MHZ;

  // ==========================================================
  // pin bundle positions
  localparam int PIN_W = 7;
  localparam int PIN_SLEEP = 0;
  localparam int PIN_EN_LEVEL = 1;
  localparam int PIN_EN_FLOAT = 2;
  localparam int PIN_UV = 3;
  localparam int PIN_OC = 4;
  localparam int PIN_CPUV = 5;
  localparam int PIN_OT = 6;

  // ==========================================================
  // register map
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_INT_STATUS = 12'h008;
  localparam logic [11:0] ADDR_INT_MASK = 12'h00c;
  localparam int CTRL_SOFT_OFF = 0;
  localparam logic CTRL_RESET = 1'b0;
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_BRIDGE = 2;
  localparam int STAT_PUMP = 3;
  localparam int STAT_READY = 4;
  localparam int STAT_OCP = 5;
  localparam int STAT_UV = 6;
  localparam int STAT_CPUV = 7;
  localparam int STAT_OT = 8;
  localparam int STAT_RETRY = 9;
  localparam int EV_W = 5;
  localparam int EV_FAULT = 0;
  localparam int EV_CLEAR = 1;
  localparam int EV_SLEEP = 2;
  localparam int EV_READY = 3;
  localparam int EV_LONG = 4;
  localparam logic [4:0] INT_RESET = 5'h00;

  // ==========================================================
  // device modes
  typedef enum logic [1:0] {
    ST_SLEEP = 2'b00,
    ST_WAKE = 2'b01,
    ST_DISABLED = 2'b10,
    ST_ACTIVE = 2'b11
  } mode_t;

endpackage

// ==== core/pin_sync.sv ====
// three-stage pin synchroniser, output follows once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  wire logic [W-1:0] agree = ~(s2 ^ s3);

  always_ff @(posedge clk) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      level <= '0;
    end else if (ce) begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      level <= (s3 & agree) | (level & ~agree);
    end
  end
endmodule

// ==== core/span_counter.sv ====
// saturating cycle counter for the mode timing windows
`timescale 1ns/1ps
module span_counter
  import mode_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic clr,
  input wire logic run,
  output logic [CNT_W-1:0] count
);
  wire logic sat = &count;

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= '0;
    end else if (ce) begin
      if (clr) begin
        count <= '0;
      end else if (run && !sat) begin
        count <= count + CNT_W'(1);
      end
    end
  end
endmodule

// ==== sim/motion_ctrl_model.sv ====
// behavioural motion controller driving the sleep and enable pins
`timescale 1ns/1ps
module motion_ctrl_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic hold_low,
  input wire logic [15:0] low_len,
  input wire logic [1:0] en_mode,
  output logic sleep_request_low,
  output logic enable_level,
  output logic enable_float,
  output logic busy
);
  logic [15:0] left;
  logic tog;
  // ==========================================================
  // sleep pin: timed low pulses or held low
  assign busy = left != 16'h0000;
  assign sleep_request_low = !(hold_low || busy);
  always_ff @(posedge clk) begin
    tog <= rst ? 1'b0 : !tog;
    if (rst) begin
      left <= 16'h0000;
    end else if (go && !busy) begin
      left <= low_len;
    end else if (busy) begin
      left <= left - 16'h0001;
    end
  end
  // ==========================================================
  // enable pin: low, high or floating (level line wanders)
  assign enable_level = en_mode[1] ? tog : en_mode[0];
  assign enable_float = en_mode[1];
endmodule

// ==== sim/testbench.sv ====
// self-checking bench for the motor driver mode control
`timescale 1ns/1ps
module testbench
  import mode_ctrl_pkg::*;
;
  typedef struct packed {logic [6:0] pins; logic [4:0] outs; logic [1:0] mode;} row_t;
  // pins: hold, float, level, uv, oc, pump uv, overtemp; outs: bridge, pump, reg, ready, fault
  localparam row_t ROWS [8] = '{14'b0010000_11110_11, 14'b0100000_11110_11,
    14'b0000000_01100_10, 14'b0011000_00101_10, 14'b1010000_00000_00,
    14'b0010010_01111_11, 14'b0010001_00111_11, 14'b0100100_01111_11};
  logic clk = 0, rst = 1, uv = 0, oc = 0, cpuv = 0, ot = 0, go = 0, hold_low = 0;
  logic psel = 0, penable = 0, pwrite = 0, er, sleep_request_low, enable_level;
  logic enable_float, busy, pready, pslverr, bridge_on, pump_run, reg_on, ready;
  logic foe_o, foe, irq, ce = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic [15:0] low_len = 16'h0000;
  logic [1:0] en_mode = 2'h1;
  int err_total = 0, check_count = 0, n, offs = 0;
  row_t r;

  always #2 clk = ~clk;
  always @(posedge clk) if (pump_run !== 1'b1 || reg_on !== 1'b1) offs++;

  motion_ctrl_model ctl (.clk(clk), .rst(rst), .go(go), .hold_low(hold_low),
    .low_len(low_len), .en_mode(en_mode), .sleep_request_low(sleep_request_low),
    .enable_level(enable_level), .enable_float(enable_float), .busy(busy));
  motor_driver_mode_control #(.CLEAR_MIN_CYCLES(10), .CLEAR_MAX_CYCLES(20),
    .SLEEP_CYCLES(40), .WAKE_CYCLES(30), .RETRY_CYCLES(50)) DUT (.clk(clk), .rst(rst),
    .ce(ce), .sleep_request_low(sleep_request_low), .enable_level(enable_level),
    .enable_float(enable_float), .supply_undervoltage_lockout(uv), .overcurrent_trip(oc),
    .pump_undervoltage(cpuv), .over_temperature(ot), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bridge_on(bridge_on), .pump_run(pump_run),
    .logic_regulator_output(reg_on), .ready(ready), .fault_flag_low_o(foe_o),
    .fault_flag_low_oe(foe), .irq(irq));

  // ==========================================================
  // tasks
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin @(posedge clk); end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic pulse(input logic [15:0] k);
    int t;
    @(posedge clk);
    go <= 1'b1; low_len <= k;
    @(posedge clk);
    go <= 1'b0;
    t = 0;
    do begin @(negedge clk); t++; end while (busy === 1'b1 && t < 500);
    cyc(10);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    conclude();
  end

  // ==========================================================
  // main sequence
  initial begin
    cyc(4);
    cmp("reset_outs", 0, 32'({bridge_on, pump_run, reg_on, ready, foe, irq, foe_o}));
    @(posedge clk) rst <= 1'b0;
    apb(0, ADDR_STATUS, 0);
    cmp("reset_mode", 32'(ST_WAKE), 32'(rd[1:0]));
    apb(0, ADDR_INT_MASK, 0);
    cmp("reset_mask", 32'(INT_RESET), rd);
    foreach (ROWS[i]) begin
      r = ROWS[i];
      @(posedge clk);
      {hold_low, en_mode, uv, oc, cpuv, ot} <= r.pins;
      cyc(100);
      cmp("outs", 32'(r.outs), 32'({bridge_on, pump_run, reg_on, ready, foe}));
      apb(0, ADDR_STATUS, 0);
      cmp("mode", 32'(r.mode), 32'(rd[1:0]));
    end
    @(posedge clk) oc <= 1'b0;
    cyc(10);
    cmp("latched", 1, 32'(foe));
    apb(1, ADDR_INT_STATUS, 32'h1f);
    pulse(5);
    cmp("short_pulse", 1, 32'(foe));
    offs = 0;
    pulse(15);
    cmp("cleared", 32'h7, 32'({bridge_on, ready, !foe}));
    cmp("no_shutdown", 0, 32'(offs));
    apb(0, ADDR_INT_STATUS, 0);
    cmp("ev_clear", 1, 32'(rd[EV_CLEAR]));
    cmp("irq_masked", 0, 32'(irq));
    apb(1, ADDR_INT_MASK, 32'h1 << EV_CLEAR);
    cyc(2);
    cmp("irq_on", 1, 32'(irq));
    apb(1, ADDR_INT_STATUS, 32'h1 << EV_CLEAR);
    cyc(2);
    cmp("irq_off", 0, 32'(irq));
    offs = 0;
    pulse(30);
    cmp("mid_pulse", 0, 32'(offs));
    @(posedge clk) hold_low <= 1'b1;
    n = 0;
    do begin @(negedge clk); n++; end while (reg_on !== 1'b0 && n < 200);
    cmp("sleep_entry", 1, 32'(n > 40 && n <= 52));
    cmp("asleep", 0, 32'({bridge_on, pump_run}));
    @(posedge clk) hold_low <= 1'b0;
    n = 0;
    do begin @(negedge clk); n++; end while (reg_on !== 1'b1 && n < 200);
    cmp("wake_exit", 1, 32'(n <= 8));
    do begin @(negedge clk); n++; end while (ready !== 1'b1 && n < 400);
    cmp("wake_delay", 1, 32'(n > 30 && n <= 45));
    @(posedge clk);
    en_mode <= 2'h1;
    oc <= 1'b1;
    cyc(8);
    @(posedge clk) oc <= 1'b0;
    cyc(15);
    cmp("retry_wait", 1, 32'(foe));
    cyc(60);
    cmp("retry_done", 32'h3, 32'({bridge_on, !foe}));
    apb(1, ADDR_CTRL, 32'h1);
    cyc(2);
    cmp("soft_off", 0, 32'(bridge_on));
    apb(1, ADDR_CTRL, 32'h0);
    cyc(2);
    cmp("soft_on", 1, 32'(bridge_on));
    @(posedge clk);
    ce <= 1'b0;
    oc <= 1'b1;
    cyc(20);
    cmp("ce_freeze", 32'h2, 32'({bridge_on, foe}));
    @(posedge clk) ce <= 1'b1;
    cyc(10);
    cmp("ce_resume", 32'h1, 32'({bridge_on, foe}));
    @(posedge clk) oc <= 1'b0;
    apb(0, 12'h010, 0);
    cmp("unmapped", 32'h1, {rd[30:0], er});
    conclude();
  end
endmodule
